// File: stpf_map.svh
`ifndef STPF_MAP_SVH
`define STPF_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define STPF_CTRL_OFS        12'h000
`define STPF_SEND_CPU_OFS    12'h004
`define STPF_DEF_VID_OFS     12'h008
`define STPF_CNT_LISTEN_OFS  12'h00C
`define STPF_CNT_LEARN_OFS   12'h010
`define STPF_CNT_BLOCK_OFS   12'h014
`define STPF_PORT_BASE       12'h040
`define STPF_EG_CNT_BASE     12'h080
`define STPF_INST_BASE       12'h100
`define STPF_VLAN_BASE       12'h400

// ****************************************************************
// Field positions
// ****************************************************************
`define STPF_CTRL_EN_BIT     0
`define STPF_CTRL_FWD_BIT    1
`define STPF_PORT_IN_LSB     0
`define STPF_PORT_EG_LSB     4
`define STPF_INST_EG_LSB     16

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define STPF_SEND_CPU_RST    2'h3
`define STPF_DEF_VID_RST     12'h001
`define STPF_BPDU_ADDR0      48'h0180C2000000
`define STPF_BPDU_ADDR1      48'h01000CCCCCCD
`define STPF_STP_DISABLED    3'h0
`define STPF_STP_BLOCKING    3'h1
`define STPF_STP_LISTENING   3'h2
`define STPF_STP_LEARNING    3'h3
`define STPF_STP_FORWARDING  3'h4
`define STPF_INST_DISCARDING 2'h0
`define STPF_INST_LEARNING   2'h1
`define STPF_INST_FORWARDING 2'h2
`define STPF_RESP_OKAY       2'h0
`define STPF_RESP_SLVERR     2'h2

`endif

// File: stpf_pkg.sv
package stpf_pkg;

  typedef logic [2:0] stpf_stp_t;
  typedef logic [1:0] stpf_inst_t;

  typedef enum logic [1:0] {
    CAUSE_NONE,
    CAUSE_LISTEN,
    CAUSE_LEARN,
    CAUSE_BLOCK
  } stpf_cause_t;

  typedef enum logic [3:0] {
    SEL_CTRL,
    SEL_SEND,
    SEL_DVID,
    SEL_CLISTEN,
    SEL_CLEARN,
    SEL_CBLOCK,
    SEL_PORT,
    SEL_EGCNT,
    SEL_INST,
    SEL_VLAN,
    SEL_NONE
  } stpf_sel_t;

endpackage : stpf_pkg

// File: stpf_dir_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "stpf_map.svh"

module stpf_dir_check
  import stpf_pkg::*;
(
  input  wire logic        filter_en,
  input  wire stpf_stp_t   stp_state,
  input  wire stpf_inst_t  inst_state,
  output logic             pass,
  output logic             learn_ok,
  output var stpf_cause_t  cause
);

  // The single-instance state is judged first so that a drop is charged to it.
  always_comb begin
    pass     = 1'b1;
    learn_ok = 1'b1;
    cause    = CAUSE_NONE;
    if (filter_en) begin
      case (stp_state)
        `STPF_STP_BLOCKING: begin
          pass     = 1'b0;
          learn_ok = 1'b0;
          cause    = CAUSE_BLOCK;
        end
        `STPF_STP_LISTENING: begin
          pass     = 1'b0;
          learn_ok = 1'b0;
          cause    = CAUSE_LISTEN;
        end
        `STPF_STP_LEARNING: begin
          pass  = 1'b0;
          cause = CAUSE_LEARN;
        end
        default: begin
        end
      endcase
      if (pass) begin
        case (inst_state)
          `STPF_INST_DISCARDING: begin
            pass     = 1'b0;
            learn_ok = 1'b0;
            cause    = CAUSE_BLOCK;
          end
          `STPF_INST_LEARNING: begin
            pass  = 1'b0;
            cause = CAUSE_LEARN;
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule : stpf_dir_check
`default_nettype wire

// File: stpf_port_filter.sv
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "stpf_map.svh"


module stpf_port_filter
  import stpf_pkg::*;
#(
  parameter int NPORTS = 4,
  parameter int NINST  = 4,
  parameter int NVLAN  = 16,
  parameter int CW     = 32
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [11:0]               s_axi_araddr,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  input  wire logic                      frame_valid,
  input  wire logic [$clog2(NPORTS)-1:0] frame_src_port,
  input  wire logic [$clog2(NPORTS)-1:0] frame_dst_port,
  input  wire logic                      frame_tagged,
  input  wire logic [11:0]               frame_vid,
  input  wire logic [47:0]               frame_dmac,
  input  wire logic                      frame_from_cpu,
  output logic                           verdict_valid,
  output logic                           verdict_forward,
  output logic                           verdict_learn,
  output logic                           verdict_to_cpu,
  output logic                           verdict_drop_ingress,
  output logic                           verdict_drop_egress
);

  localparam int AW = 12;
  localparam int PW = $clog2(NPORTS);
  localparam int IW = $clog2(NINST);
  localparam int VW = $clog2(NVLAN);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                               filter_en;
    logic                               fwd_cpu;
    logic [1:0]                         send_cpu;
    logic [11:0]                        default_vid;
    logic [NPORTS-1:0][2:0]             in_stp;
    logic [NPORTS-1:0][2:0]             egress_tree_state;
    logic [NINST-1:0][NPORTS-1:0][1:0]  in_inst;
    logic [NINST-1:0][NPORTS-1:0][1:0]  eg_inst;
    logic [NVLAN-1:0][IW-1:0]           instance_table_index;
    logic [CW-1:0]                      cnt_listen;
    logic [CW-1:0]                      cnt_learn;
    logic [CW-1:0]                      cnt_block;
    logic [NPORTS-1:0][CW-1:0]          cnt_egress;
    logic                               aw_got;
    logic                               w_got;
    logic [AW-1:0]                      waddr;
    logic [31:0]                        wdata;
    logic [3:0]                         wstrb;
    logic                               bvalid;
    logic [1:0]                         bresp;
    logic                               rvalid;
    logic [1:0]                         rresp;
    logic [31:0]                        rdata;
    logic                               v_valid;
    logic                               v_forward;
    logic                               v_learn;
    logic                               v_to_cpu;
    logic                               v_drop_in;
    logic                               v_drop_eg;
  } stpf_state_t;

  // Instance states come up Forwarding so single-instance mode works untouched.
  localparam stpf_state_t RST = '{
    send_cpu:             `STPF_SEND_CPU_RST,
    default_vid:          `STPF_DEF_VID_RST,
    in_stp:               {NPORTS{`STPF_STP_DISABLED}},
    egress_tree_state:    {NPORTS{`STPF_STP_DISABLED}},
    in_inst:              {(NINST*NPORTS){`STPF_INST_FORWARDING}},
    eg_inst:              {(NINST*NPORTS){`STPF_INST_FORWARDING}},
    default:              '0
  };

  stpf_state_t q;
  stpf_state_t d;

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  function automatic stpf_sel_t reg_sel(input logic [AW-1:0] a);
    reg_sel = SEL_NONE;
    if (a[1:0] != 2'h0) reg_sel = SEL_NONE;
    else if (a == `STPF_CTRL_OFS) reg_sel = SEL_CTRL;
    else if (a == `STPF_SEND_CPU_OFS) reg_sel = SEL_SEND;
    else if (a == `STPF_DEF_VID_OFS) reg_sel = SEL_DVID;
    else if (a == `STPF_CNT_LISTEN_OFS) reg_sel = SEL_CLISTEN;
    else if (a == `STPF_CNT_LEARN_OFS) reg_sel = SEL_CLEARN;
    else if (a == `STPF_CNT_BLOCK_OFS) reg_sel = SEL_CBLOCK;
    else if (a >= `STPF_PORT_BASE && a < `STPF_PORT_BASE + AW'(NPORTS * 4)) reg_sel = SEL_PORT;
    else if (a >= `STPF_EG_CNT_BASE && a < `STPF_EG_CNT_BASE + AW'(NPORTS * 4)) reg_sel = SEL_EGCNT;
    else if (a >= `STPF_INST_BASE && a < `STPF_INST_BASE + AW'(NINST * 4)) reg_sel = SEL_INST;
    else if (a >= `STPF_VLAN_BASE && a < `STPF_VLAN_BASE + AW'(NVLAN * 4)) reg_sel = SEL_VLAN;
  endfunction : reg_sel

  function automatic logic [7:0] reg_idx(input logic [AW-1:0] a);
    logic [AW-1:0] base;
    case (reg_sel(a))
      SEL_PORT:  base = `STPF_PORT_BASE;
      SEL_EGCNT: base = `STPF_EG_CNT_BASE;
      SEL_INST:  base = `STPF_INST_BASE;
      SEL_VLAN:  base = `STPF_VLAN_BASE;
      default:   base = a;
    endcase
    reg_idx = 8'((a - base) >> 2);
  endfunction : reg_idx

  function automatic logic [31:0] rd_word(input stpf_state_t s, input logic [AW-1:0] a);
    logic [7:0] i;
    i       = reg_idx(a);
    rd_word = '0;
    case (reg_sel(a))
      SEL_CTRL: begin
        rd_word[`STPF_CTRL_EN_BIT]  = s.filter_en;
        rd_word[`STPF_CTRL_FWD_BIT] = s.fwd_cpu;
      end
      SEL_SEND:    rd_word[1:0] = s.send_cpu;
      SEL_DVID:    rd_word[11:0] = s.default_vid;
      SEL_CLISTEN: rd_word[CW-1:0] = s.cnt_listen;
      SEL_CLEARN:  rd_word[CW-1:0] = s.cnt_learn;
      SEL_CBLOCK:  rd_word[CW-1:0] = s.cnt_block;
      SEL_PORT: begin
        rd_word[`STPF_PORT_IN_LSB +: 3] = s.in_stp[i[PW-1:0]];
        rd_word[`STPF_PORT_EG_LSB +: 3] = s.egress_tree_state[i[PW-1:0]];
      end
      SEL_EGCNT:   rd_word[CW-1:0] = s.cnt_egress[i[PW-1:0]];
      SEL_INST: begin
        for (int p = 0; p < NPORTS; p++) begin
          rd_word[2*p +: 2]                     = s.in_inst[i[IW-1:0]][p];
          rd_word[`STPF_INST_EG_LSB + 2*p +: 2] = s.eg_inst[i[IW-1:0]][p];
        end
      end
      SEL_VLAN:    rd_word[IW-1:0] = s.instance_table_index[i[VW-1:0]];
      default:     rd_word = '0;
    endcase
  endfunction : rd_word

  // ****************************************************************
  // Per-direction state checks
  // ****************************************************************
  logic [11:0]  vid_eff;
  logic [IW-1:0] inst_sel;
  logic         in_pass;
  logic         in_learn;
  stpf_cause_t  in_cause;
  logic         eg_pass;
  logic         eg_learn_unused;
  stpf_cause_t  eg_cause_unused;
  logic         bpdu_hit;
  logic         cpu_bypass;

  assign vid_eff  = frame_tagged ? frame_vid : q.default_vid;
  assign inst_sel = q.instance_table_index[vid_eff[VW-1:0]];
  assign bpdu_hit = !frame_from_cpu
                  && ((q.send_cpu[0] && frame_dmac == `STPF_BPDU_ADDR0)
                  ||  (q.send_cpu[1] && frame_dmac == `STPF_BPDU_ADDR1));
  assign cpu_bypass = frame_from_cpu && q.fwd_cpu;

  stpf_dir_check u_ingress (
    .filter_en  (q.filter_en),
    .stp_state  (q.in_stp[frame_src_port]),
    .inst_state (q.in_inst[inst_sel][frame_src_port]),
    .pass       (in_pass),
    .learn_ok   (in_learn),
    .cause      (in_cause)
  );

  stpf_dir_check u_egress (
    .filter_en  (q.filter_en),
    .stp_state  (q.egress_tree_state[frame_dst_port]),
    .inst_state (q.eg_inst[inst_sel][frame_dst_port]),
    .pass       (eg_pass),
    .learn_ok   (eg_learn_unused),
    .cause      (eg_cause_unused)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [31:0] wv;
    logic [7:0]  wi;
    wv = '0;
    wi = '0;
    d  = q;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Counters are read-only; a write to them is accepted and has no effect.
    if (d.aw_got && d.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = (reg_sel(d.waddr) == SEL_NONE) ? `STPF_RESP_SLVERR : `STPF_RESP_OKAY;
      wi       = reg_idx(d.waddr);
      wv       = rd_word(q, d.waddr);
      for (int b = 0; b < 4; b++) begin
        if (d.wstrb[b]) wv[8*b +: 8] = d.wdata[8*b +: 8];
      end
      case (reg_sel(d.waddr))
        SEL_CTRL: begin
          d.filter_en = wv[`STPF_CTRL_EN_BIT];
          d.fwd_cpu   = wv[`STPF_CTRL_FWD_BIT];
        end
        SEL_SEND: d.send_cpu = wv[1:0];
        SEL_DVID: d.default_vid = wv[11:0];
        SEL_PORT: begin
          d.in_stp[wi[PW-1:0]]            = wv[`STPF_PORT_IN_LSB +: 3];
          d.egress_tree_state[wi[PW-1:0]] = wv[`STPF_PORT_EG_LSB +: 3];
        end
        SEL_INST: begin
          for (int p = 0; p < NPORTS; p++) begin
            d.in_inst[wi[IW-1:0]][p] = wv[2*p +: 2];
            d.eg_inst[wi[IW-1:0]][p] = wv[`STPF_INST_EG_LSB + 2*p +: 2];
          end
        end
        SEL_VLAN: d.instance_table_index[wi[VW-1:0]] = wv[IW-1:0];
        default: begin
        end
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_word(q, s_axi_araddr);
      d.rresp  = (reg_sel(s_axi_araddr) == SEL_NONE) ? `STPF_RESP_SLVERR : `STPF_RESP_OKAY;
    end
    d.v_valid   = frame_valid;
    d.v_forward = 1'b0;
    d.v_learn   = 1'b0;
    d.v_to_cpu  = 1'b0;
    d.v_drop_in = 1'b0;
    d.v_drop_eg = 1'b0;
    if (frame_valid) begin
      d.v_learn = in_learn;
      if (bpdu_hit) begin
        d.v_to_cpu = 1'b1;
      end else if (!in_pass) begin
        d.v_drop_in = 1'b1;
        case (in_cause)
          CAUSE_LISTEN: d.cnt_listen = q.cnt_listen + CW'(1);
          CAUSE_LEARN:  d.cnt_learn  = q.cnt_learn + CW'(1);
          default:      d.cnt_block  = q.cnt_block + CW'(1);
        endcase
      end else if (!eg_pass && !cpu_bypass) begin
        d.v_drop_eg = 1'b1;
        d.cnt_egress[frame_dst_port] = q.cnt_egress[frame_dst_port] + CW'(1);
      end else begin
        d.v_forward = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready        = !q.aw_got && !q.bvalid;
  assign s_axi_wready         = !q.w_got && !q.bvalid;
  assign s_axi_bvalid         = q.bvalid;
  assign s_axi_bresp          = q.bresp;
  assign s_axi_arready        = !q.rvalid;
  assign s_axi_rvalid         = q.rvalid;
  assign s_axi_rdata          = q.rdata;
  assign s_axi_rresp          = q.rresp;
  assign verdict_valid        = q.v_valid;
  assign verdict_forward      = q.v_forward;
  assign verdict_learn        = q.v_learn;
  assign verdict_to_cpu       = q.v_to_cpu;
  assign verdict_drop_ingress = q.v_drop_in;
  assign verdict_drop_egress  = q.v_drop_eg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [NPORTS+2:0] cnt_moved;

  always_comb begin
    cnt_moved[0] = d.cnt_listen != q.cnt_listen;
    cnt_moved[1] = d.cnt_learn != q.cnt_learn;
    cnt_moved[2] = d.cnt_block != q.cnt_block;
    for (int p = 0; p < NPORTS; p++) begin
      cnt_moved[3+p] = d.cnt_egress[p] != q.cnt_egress[p];
    end
  end

  filter_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_valid && !q.filter_en && !bpdu_hit |=> verdict_forward && verdict_learn)
    else $error("frame not passed while filtering is off");

  bpdu_trap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_valid && bpdu_hit |=> verdict_to_cpu && !verdict_forward && !verdict_drop_ingress)
    else $error("trapped address not sent to the CPU");

  cpu_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_valid && in_pass && !bpdu_hit && frame_from_cpu && q.fwd_cpu |=> verdict_forward)
    else $error("CPU frame held by egress state");

  egress_learn_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_valid && in_pass && !eg_pass |=> verdict_learn)
    else $error("learning affected by egress state");

  blocking_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_valid && q.filter_en && !bpdu_hit && q.in_stp[frame_src_port] == `STPF_STP_BLOCKING
    |=> verdict_drop_ingress && !verdict_learn && q.cnt_block == $past(q.cnt_block) + CW'(1))
    else $error("blocking state did not drop and count");

  learning_state_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_valid && q.filter_en && !bpdu_hit && q.in_stp[frame_src_port] == `STPF_STP_LEARNING
    |=> verdict_learn && !verdict_forward && q.cnt_learn == $past(q.cnt_learn) + CW'(1))
    else $error("learning state verdict wrong");

  one_counter_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0(cnt_moved) && (|cnt_moved == (frame_valid && !bpdu_hit && !(in_pass && (eg_pass || cpu_bypass)))))
    else $error("drop counter update count wrong");

  egress_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    verdict_drop_egress
    |-> q.cnt_egress[$past(frame_dst_port)] == $past(q.cnt_egress[frame_dst_port]) + CW'(1))
    else $error("egress drop not counted on its port");

  inst_discard_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_valid && q.filter_en && !bpdu_hit && in_cause == CAUSE_BLOCK
    |=> verdict_drop_ingress && q.cnt_block == $past(q.cnt_block) + CW'(1))
    else $error("discarding drop not on blocking counter");

endmodule : stpf_port_filter
`default_nettype wire

// File: stpf_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Frame source standing in for the packet pipeline
// ****************************************************************
module stpf_pipe_model #(
  parameter int NPORTS = 4
) (
  input  wire logic                      aclk,
  output logic                           frame_valid,
  output logic [$clog2(NPORTS)-1:0]      frame_src_port,
  output logic [$clog2(NPORTS)-1:0]      frame_dst_port,
  output logic                           frame_tagged,
  output logic [11:0]                    frame_vid,
  output logic [47:0]                    frame_dmac,
  output logic                           frame_from_cpu
);
  initial begin
    frame_valid = 1'b0;
    {frame_src_port, frame_dst_port, frame_tagged, frame_vid, frame_dmac, frame_from_cpu} = '0;
  end
  // Fields idle inverted between frames so stale values never pass for live ones.
  task automatic send(input logic [$clog2(NPORTS)-1:0] s, d, input logic t, input logic [11:0] v,
                      input logic [47:0] m, input logic c);
    @(posedge aclk);
    frame_valid <= 1'b1;
    {frame_src_port, frame_dst_port, frame_tagged, frame_vid, frame_dmac, frame_from_cpu} <= {s, d, t, v, m, c};
    @(posedge aclk);
    frame_valid <= 1'b0;
    {frame_src_port, frame_dst_port, frame_tagged, frame_vid, frame_dmac, frame_from_cpu} <= ~{s, d, t, v, m, c};
  endtask : send
endmodule : stpf_pipe_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "stpf_map.svh"
// ****************************************************************
// Self-checking bench
// ****************************************************************
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        awr, wr_rdy, bv, arr, rv, fv, ft, fc, vv, vf, vl, vc, vdi, vde;
  logic [11:0] awa = 12'h000, ara = 12'h000, fvid;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0]  ws = 4'hF;
  logic [1:0]  bresp, rresp, fs, fd;
  logic [47:0] fm;
  int          n_fail = 0, checked = 0;
  localparam logic [47:0] NRM = 48'h02AABBCCDDEE;

  always #12.5 aclk = ~aclk;

  stpf_pipe_model #(.NPORTS(4)) pm_u (.aclk(aclk), .frame_valid(fv), .frame_src_port(fs),
    .frame_dst_port(fd), .frame_tagged(ft), .frame_vid(fvid), .frame_dmac(fm), .frame_from_cpu(fc));

  stpf_port_filter #(.NPORTS(4), .NINST(4), .NVLAN(16), .CW(32)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .frame_valid(fv), .frame_src_port(fs), .frame_dst_port(fd),
    .frame_tagged(ft), .frame_vid(fvid), .frame_dmac(fm), .frame_from_cpu(fc), .verdict_valid(vv),
    .verdict_forward(vf), .verdict_learn(vl), .verdict_to_cpu(vc), .verdict_drop_ingress(vdi),
    .verdict_drop_egress(vde));

  task automatic chk_r(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk_r

  task automatic chk_v(input string n, input logic [5:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask : chk_v

  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {awv, wv, br, awa, wd} <= {3'h7, a, d};
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    r = bresp;
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {arv, rr, ara} <= {2'h3, a};
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    d = rd;
    r = rresp;
  endtask : axr

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
  endtask : wr

  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk_r(n, e, d);
  endtask : rd_chk

  task automatic port_set(input int p, input logic [2:0] i, e);
    wr(`STPF_PORT_BASE + 12'(4 * p), {25'h0, e, 1'b0, i});
  endtask : port_set

  task automatic fr(input logic [1:0] s, d, input logic t, input logic [11:0] v, input logic [47:0] m,
                    input logic c, input logic [4:0] e);
    pm_u.send(s, d, t, v, m, c);
    #1;
    chk_v("verdict", {1'b1, e}, {vv, vf, vl, vc, vdi, vde});
  endtask : fr

  // Result order is forward, learn, to_cpu, drop_ingress, drop_egress.
  function automatic logic [4:0] ev(input logic [2:0] is, es, input logic [1:0] ii, ei, input logic bp, co);
    logic ln, ip, ep;
    ln = (is != 3'h1) && (is != 3'h2) && (ii != 2'h0);
    ip = (is == 3'h0 || is == 3'h4) && ii == 2'h2;
    ep = co || ((es == 3'h0 || es == 3'h4) && ei == 2'h2);
    if (bp) return {1'b0, ln, 3'b100};
    if (!ip) return {1'b0, ln, 3'b010};
    return {ep, ln, 2'b00, !ep};
  endfunction : ev

  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  initial begin
    #(25 * 8000);
    n_fail++;
    complete_run();
  end

  initial begin
    logic [31:0] x;
    logic [1:0]  r;
    x = $urandom(32'h5314);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("send_cpu", `STPF_SEND_CPU_OFS, 32'h3);
    rd_chk("def_vid", `STPF_DEF_VID_OFS, 32'h1);
    rd_chk("ctrl", `STPF_CTRL_OFS, 32'h0);
    port_set(1, 3'h1, 3'h1);
    fr(2'h1, 2'h2, 1'b0, 12'h0, NRM, 1'b0, 5'b11000);
    $display("test reset done");
    wr(`STPF_CTRL_OFS, 32'h1);
    for (int k = 0; k < 5; k++) begin
      port_set(1, 3'(k), 3'h0);
      fr(2'h1, 2'h2, 1'b0, 12'h0, NRM, 1'b0, ev(3'(k), 3'h0, 2'h2, 2'h2, 1'b0, 1'b0));
    end
    rd_chk("cnt_listen", `STPF_CNT_LISTEN_OFS, 32'h1);
    rd_chk("cnt_learn", `STPF_CNT_LEARN_OFS, 32'h1);
    rd_chk("cnt_block", `STPF_CNT_BLOCK_OFS, 32'h1);
    $display("test single states done");
    port_set(1, 3'h1, 3'h0);
    fr(2'h1, 2'h2, 1'b0, 12'h0, `STPF_BPDU_ADDR0, 1'b0, ev(3'h1, 3'h0, 2'h2, 2'h2, 1'b1, 1'b0));
    fr(2'h1, 2'h2, 1'b0, 12'h0, `STPF_BPDU_ADDR1, 1'b0, ev(3'h1, 3'h0, 2'h2, 2'h2, 1'b1, 1'b0));
    wr(`STPF_SEND_CPU_OFS, 32'h2);
    fr(2'h1, 2'h2, 1'b0, 12'h0, `STPF_BPDU_ADDR0, 1'b0, ev(3'h1, 3'h0, 2'h2, 2'h2, 1'b0, 1'b0));
    rd_chk("cnt_block", `STPF_CNT_BLOCK_OFS, 32'h2);
    wr(`STPF_SEND_CPU_OFS, 32'h3);
    $display("test bpdu done");
    port_set(1, 3'h4, 3'h0);
    port_set(2, 3'h0, 3'h1);
    fr(2'h1, 2'h2, 1'b0, 12'h0, NRM, 1'b0, ev(3'h4, 3'h1, 2'h2, 2'h2, 1'b0, 1'b0));
    fr(2'h1, 2'h2, 1'b0, 12'h0, NRM, 1'b1, ev(3'h4, 3'h1, 2'h2, 2'h2, 1'b0, 1'b0));
    wr(`STPF_CTRL_OFS, 32'h3);
    fr(2'h1, 2'h2, 1'b0, 12'h0, NRM, 1'b1, ev(3'h4, 3'h1, 2'h2, 2'h2, 1'b0, 1'b1));
    rd_chk("eg_cnt2", `STPF_EG_CNT_BASE + 12'h8, 32'h2);
    rd_chk("eg_cnt1", `STPF_EG_CNT_BASE + 12'h4, 32'h0);
    $display("test egress done");
    port_set(1, 3'h0, 3'h0);
    port_set(2, 3'h0, 3'h0);
    wr(`STPF_VLAN_BASE + 12'h14, 32'h2);
    wr(`STPF_INST_BASE + 12'h8, 32'h00AA00A6);
    fr(2'h1, 2'h2, 1'b1, 12'h5, NRM, 1'b0, ev(3'h0, 3'h0, 2'h1, 2'h2, 1'b0, 1'b0));
    wr(`STPF_DEF_VID_OFS, 32'h5);
    fr(2'h1, 2'h2, 1'b0, 12'h9, NRM, 1'b0, ev(3'h0, 3'h0, 2'h1, 2'h2, 1'b0, 1'b0));
    fr(2'h1, 2'h2, 1'b1, 12'h9, NRM, 1'b0, 5'b11000);
    wr(`STPF_INST_BASE + 12'h8, 32'h00AA00A2);
    fr(2'h1, 2'h2, 1'b1, 12'h5, NRM, 1'b0, ev(3'h0, 3'h0, 2'h0, 2'h2, 1'b0, 1'b0));
    wr(`STPF_INST_BASE + 12'h8, 32'h009A00AA);
    fr(2'h1, 2'h2, 1'b1, 12'h5, NRM, 1'b0, ev(3'h0, 3'h0, 2'h2, 2'h1, 1'b0, 1'b0));
    rd_chk("cnt_learn", `STPF_CNT_LEARN_OFS, 32'h3);
    rd_chk("cnt_block", `STPF_CNT_BLOCK_OFS, 32'h3);
    rd_chk("eg_cnt2", `STPF_EG_CNT_BASE + 12'h8, 32'h3);
    $display("test instances done");
    wr(`STPF_INST_BASE + 12'h8, 32'h00AA00AA);
    for (int k = 0; k < 24; k++) begin
      x = $urandom;
      fr(x[1:0], x[3:2], x[4], x[16:5], {8'h02, x, 8'h11}, x[17], 5'b11000);
    end
    $display("test random done");
    axw(12'h200, 32'h1, r);
    chk_r("bresp", 32'(`STPF_RESP_SLVERR), 32'(r));
    axr(12'h200, x, r);
    chk_r("rresp", 32'(`STPF_RESP_SLVERR), 32'(r));
    chk_r("rdata", 32'h0, x);
    wr(`STPF_CNT_LEARN_OFS, 32'h0);
    rd_chk("cnt_learn", `STPF_CNT_LEARN_OFS, 32'h3);
    // Only the low byte lane is enabled, so the upper lanes must keep the old value.
    ws <= 4'h1;
    wr(`STPF_DEF_VID_OFS, 32'hFFFFFF07);
    rd_chk("def_vid_strb", `STPF_DEF_VID_OFS, 32'h7);
    ws <= 4'hF;
    $display("test bus done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
